// File: bpv_consts.vh
`ifndef BPV_CONSTS_VH
`define BPV_CONSTS_VH
// ************************************************************
// Register byte offsets
// ************************************************************
`define BPV_OFF_BASE      12'h000
`define BPV_OFF_LMODE     12'h004
`define BPV_OFF_XMODE     12'h008
`define BPV_OFF_CTRL      12'h00C
`define BPV_OFF_COUNT     12'h010
`define BPV_LPAL_TAG      6'h04
`define BPV_XPAL_TAG      2'h1
// ************************************************************
// Field positions
// ************************************************************
`define BPV_CTRL_ENABLE   0
`define BPV_CTRL_XFAM     1
`define BPV_XM_BANK_LSB   0
`define BPV_XM_MODE_LSB   8
`define BPV_XM_GREY       12
`define BPV_XM_HOLD       15
`define BPV_INV_MONO      0
`define BPV_INV_DUO       1
// ************************************************************
// Reset values
// ************************************************************
`define BPV_RST_BASE      21'h000000
`define BPV_RST_LMODE     2'h0
`define BPV_RST_XMODE     16'h0000
`define BPV_RST_CTRL      2'h0
// ************************************************************
// Mode codes and fixed figures
// ************************************************************
`define BPV_LM_320X200    2'h0
`define BPV_LM_640X200    2'h1
`define BPV_LM_640X400    2'h2
`define BPV_XM_320X200    3'h0
`define BPV_XM_640X200    3'h1
`define BPV_XM_640X400    3'h2
`define BPV_XM_640X480    3'h4
`define BPV_XM_1280X960   3'h6
`define BPV_XM_320X480    3'h7
`define BPV_DUO_BASE      7'h7F
`define BPV_FETCH_BYTES   24'h000008
`endif

// File: bpv_video.v
// What this block does
// [R1] Mode from legacy or extended mode register
// [R2] Sixteen legacy entries, three bits per gun
// [R3] Mode 00 all sixteen, 01 first four
// [R4] Legacy mono inverts by entry zero bit0
// [R5] Multi-plane border shows palette entry zero
// [R6] 256 extended entries, four bits per gun
// [R7] Four bank bits select sixteen extended banks
// [R8] Eight-plane mode indexes all 256 directly
// [R9] Two-colour uses entries 254 and 255
// [R10] Two-colour inverts by invert_bit of entry zero
// [R11] Grey mode: green high, blue low nibble
// [R12] Planes of interleaved 16-bit words
// [R13] Software aligns buffer to eight bytes
// [R14] Base top byte always reads zero
// [R15] Counter reloads from base each frame
// [R16] Memory fetched 64 bits per transfer
// [R17] First plane gives index least significant bit
// [R18] Extended register: hold, grey, mode, bank
// [R19] Legacy codes 00, 01, 10; 11 reserved
// [R20] Bank bits concatenated above pixel index
// [R21] Reserved mode blanks the pixel output
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`include "bpv_consts.vh"
module bpv_video #(
   parameter AW = 12
)(
   // Clock, reset, enable
   input  wire          clock,
   input  wire          srst,
   input  wire          ce,
   // AXI4-Lite write
   input  wire [AW-1:0] s_axi_awaddr,
   input  wire          s_axi_awvalid,
   output wire          s_axi_awready,
   input  wire [31:0]   s_axi_wdata,
   input  wire [3:0]    s_axi_wstrb,
   input  wire          s_axi_wvalid,
   output wire          s_axi_wready,
   output reg  [1:0]    s_axi_bresp,
   output reg           s_axi_bvalid,
   input  wire          s_axi_bready,
   // AXI4-Lite read
   input  wire [AW-1:0] s_axi_araddr,
   input  wire          s_axi_arvalid,
   output wire          s_axi_arready,
   output reg  [31:0]   s_axi_rdata,
   output reg  [1:0]    s_axi_rresp,
   output reg           s_axi_rvalid,
   input  wire          s_axi_rready,
   // Display memory fetch
   output wire          mem_req,
   output wire [23:0]   mem_addr,
   input  wire          mem_ack,
   input  wire [63:0]   mem_data,
   // Raster timing
   input  wire          frame_start,
   input  wire          active,
   input  wire          pix_tick,
   // Colour to DACs
   output reg  [7:0]    red,
   output reg  [7:0]    green,
   output reg  [7:0]    blue
);
   // ************************************************************
   // Kinds of colour resolution
   // ************************************************************
   localparam K_BLANK  = 3'h0;
   localparam K_LPAL   = 3'h1;
   localparam K_MONO   = 3'h2;
   localparam K_BANK   = 3'h3;
   localparam K_DUO    = 3'h4;
   localparam K_DIRECT = 3'h5;

   // ************************************************************
   // Registers and storage
   // ************************************************************
   reg  [23:3]  base;
   reg  [1:0]   lmode;
   reg  [15:0]  xmode;
   reg  [1:0]   ctrl;
   reg  [23:0]  addr_cnt;
   reg  [8:0]   lpal [0:15];
   reg  [11:0]  epal [0:255];
   reg  [127:0] fbuf;
   reg  [3:0]   wcnt;
   reg  [127:0] shreg;
   reg  [4:0]   shcnt;
   reg  [3:0]   np;
   reg  [2:0]   kind;
   reg  [31:0]  rd_val;
   reg          rd_err;
   reg          wr_err;
   reg  [7:0]   idx;
   reg  [7:0]   next_red;
   reg  [7:0]   next_green;
   reg  [7:0]   next_blue;
   reg  [8:0]   lent;
   reg  [11:0]  xent;
   reg          use_x;
   reg          mono_bit;

   wire         en     = ctrl[`BPV_CTRL_ENABLE];
   wire         xfam   = ctrl[`BPV_CTRL_XFAM];
   wire [2:0]   xm     = xmode[`BPV_XM_MODE_LSB +: 3];
   wire [3:0]   bank   = xmode[`BPV_XM_BANK_LSB +: 4];
   wire         grey   = xmode[`BPV_XM_GREY];
   wire         wr_go  = ce & s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   wire         rd_go  = ce & s_axi_arvalid & ~s_axi_rvalid;
   wire [AW-1:0] wa    = s_axi_awaddr;
   wire [AW-1:0] ra    = s_axi_araddr;
   wire         w_lpal = (wa[11:6] == `BPV_LPAL_TAG);
   wire         w_xpal = (wa[11:10] == `BPV_XPAL_TAG);

   assign s_axi_awready = wr_go;
   assign s_axi_wready  = wr_go;
   assign s_axi_arready = rd_go;

   function [31:0] merge;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  stb;
      integer      i;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            merge[8*i +: 8] = stb[i] ? nw[8*i +: 8] : old[8*i +: 8];
         end
      end
   endfunction

   // ************************************************************
   // Mode decode
   // ************************************************************
   always @* begin
      np   = 4'h1;
      kind = K_BLANK;
      // [R1] Family selects register
      if (!xfam) begin
         // [R19] Legacy mode codes
         case (lmode)
            `BPV_LM_320X200: begin
               np   = 4'h4;
               kind = K_LPAL;
            end
            `BPV_LM_640X200: begin
               np   = 4'h2;
               kind = K_LPAL;
            end
            `BPV_LM_640X400: begin
               np   = 4'h1;
               kind = K_MONO;
            end
            // [R21] Reserved code blanks
            default: begin
               np   = 4'h1;
               kind = K_BLANK;
            end
         endcase
      end else begin
         case (xm)
            `BPV_XM_320X200: begin
               np   = 4'h4;
               kind = K_BANK;
            end
            `BPV_XM_640X200: begin
               np   = 4'h2;
               kind = K_BANK;
            end
            `BPV_XM_640X400: begin
               np   = 4'h1;
               kind = K_DUO;
            end
            `BPV_XM_640X480: begin
               np   = 4'h4;
               kind = K_BANK;
            end
            `BPV_XM_1280X960: begin
               np   = 4'h1;
               kind = K_MONO;
            end
            `BPV_XM_320X480: begin
               np   = 4'h8;
               kind = K_DIRECT;
            end
            // [R21] Reserved code blanks
            default: begin
               np   = 4'h1;
               kind = K_BLANK;
            end
         endcase
      end
   end

   // ************************************************************
   // Fetch buffer and address counter
   // ************************************************************
   // Fetch only with room for a whole 64-bit word, so no data is dropped
   wire         load     = en & (shcnt == 5'h00) & (wcnt >= np) & ~frame_start;
   assign mem_req        = ce & en & (wcnt <= 4'h4) & ~frame_start;
   assign mem_addr       = addr_cnt;
   wire         fetch    = mem_req & mem_ack;
   wire [3:0]   wc_after = load ? (wcnt - np) : wcnt;
   wire [7:0]   shamt    = load ? {np, 4'h0} : 8'h00;
   wire [127:0] appended = {64'h0, mem_data} << {wc_after, 4'h0};

   always @(posedge clock) begin
      if (srst) begin
         addr_cnt <= 24'h000000;
         fbuf     <= 128'h0;
         wcnt     <= 4'h0;
      end else if (ce) begin
         // [R15] Reload counter each frame
         if (frame_start) begin
            addr_cnt <= {base, 3'h0};
            fbuf     <= 128'h0;
            wcnt     <= 4'h0;
         end else begin
            // [R16] 64-bit fetch unit
            if (fetch) begin
               addr_cnt <= addr_cnt + `BPV_FETCH_BYTES;
            end
            // [R12] Interleaved plane words
            fbuf <= (fbuf >> shamt) | (fetch ? appended : 128'h0);
            wcnt <= wc_after + (fetch ? 4'h4 : 4'h0);
         end
      end
   end

   // ************************************************************
   // Shift register, one bit per plane per pixel
   // ************************************************************
   wire emit = pix_tick & active & en & (shcnt != 5'h00);

   always @(posedge clock) begin
      if (srst) begin
         shcnt <= 5'h00;
      end else if (ce) begin
         if (frame_start) begin
            shcnt <= 5'h00;
         end else if (load) begin
            shcnt <= 5'h10;
         end else if (emit) begin
            shcnt <= shcnt - 5'h01;
         end
      end
   end

   genvar p;
   generate
      for (p = 0; p < 8; p = p + 1) begin : g_plane
         always @(posedge clock) begin
            if (srst) begin
               shreg[16*p +: 16] <= 16'h0000;
            end else if (ce) begin
               if (load) begin
                  shreg[16*p +: 16] <= fbuf[16*p +: 16];
               end else if (emit) begin
                  shreg[16*p +: 16] <= {shreg[16*p +: 15], 1'b0};
               end
            end
         end
         // [R17] First plane is index bit 0
         always @* begin
            idx[p] = (p < np) ? shreg[16*p + 15] : 1'b0;
         end
      end
   endgenerate

   // ************************************************************
   // Colour resolution
   // ************************************************************
   always @* begin
      // [R3] Index masked by plane count
      lent       = lpal[idx[3:0]];
      xent       = epal[idx];
      use_x      = 1'b0;
      mono_bit   = 1'b0;
      next_red   = 8'h00;
      next_green = 8'h00;
      next_blue  = 8'h00;
      case (kind)
         // [R20] Bank above pixel index
         // [R7] Bank selects extended bank
         K_BANK: begin
            xent  = epal[{bank, idx[3:0]}];
            use_x = 1'b1;
         end
         // [R8] Direct eight-bit index
         K_DIRECT: begin
            use_x = 1'b1;
         end
         // [R9] Entries 254 and 255
         // [R10] Two-colour inversion
         K_DUO: begin
            xent  = epal[{`BPV_DUO_BASE,
                          idx[0] ^ lpal[0][`BPV_INV_DUO] ^ epal[0][`BPV_INV_DUO]}];
            use_x = 1'b1;
         end
         // [R4] Mono inverter, no lookup
         K_MONO: begin
            mono_bit = idx[0] ^ lpal[0][`BPV_INV_MONO];
         end
         default: begin
            use_x = 1'b0;
         end
      endcase
      // [R5] Border from entry zero
      if (!active && np != 4'h1 && kind != K_BLANK) begin
         lent = lpal[0];
         xent = epal[0];
      end
      if (kind == K_MONO) begin
         next_red   = {8{mono_bit}};
         next_green = {8{mono_bit}};
         next_blue  = {8{mono_bit}};
      end else if (use_x && grey) begin
         // [R11] Grey level from green and blue
         next_red   = {xent[7:4], xent[3:0]};
         next_green = {xent[7:4], xent[3:0]};
         next_blue  = {xent[7:4], xent[3:0]};
      end else if (use_x) begin
         // [R6] Four bits per gun
         next_red   = {xent[11:8], xent[11:8]};
         next_green = {xent[7:4], xent[7:4]};
         next_blue  = {xent[3:0], xent[3:0]};
      end else if (kind == K_LPAL) begin
         // [R2] Three bits per gun
         next_red   = {lent[8:6], lent[8:6], lent[8:7]};
         next_green = {lent[5:3], lent[5:3], lent[5:4]};
         next_blue  = {lent[2:0], lent[2:0], lent[2:1]};
      end
      // Underrun or single-plane border shows black rather than stale data
      if (!en || (active && shcnt == 5'h00) || (!active && (np == 4'h1 || kind == K_BLANK))) begin
         next_red   = 8'h00;
         next_green = 8'h00;
         next_blue  = 8'h00;
      end
   end

   always @(posedge clock) begin
      if (srst) begin
         red   <= 8'h00;
         green <= 8'h00;
         blue  <= 8'h00;
      end else if (ce && pix_tick) begin
         red   <= next_red;
         green <= next_green;
         blue  <= next_blue;
      end
   end

   // ************************************************************
   // Register write channel
   // ************************************************************
   always @* begin
      wr_err = 1'b0;
      if (!w_lpal && !w_xpal && wa != `BPV_OFF_BASE && wa != `BPV_OFF_LMODE &&
          wa != `BPV_OFF_XMODE && wa != `BPV_OFF_CTRL) begin
         wr_err = 1'b1;
      end
   end

   wire [31:0]  m_lp = merge({23'h0, lpal[wa[5:2]]}, s_axi_wdata, s_axi_wstrb);
   wire [31:0]  m_ep = merge({20'h0, epal[wa[9:2]]}, s_axi_wdata, s_axi_wstrb);
   wire [31:0]  m_bs = merge({8'h00, base, 3'h0}, s_axi_wdata, s_axi_wstrb);
   wire [31:0]  m_lm = merge({30'h0, lmode}, s_axi_wdata, s_axi_wstrb);
   wire [31:0]  m_xm = merge({16'h0, xmode}, s_axi_wdata, s_axi_wstrb);
   wire [31:0]  m_ct = merge({30'h0, ctrl}, s_axi_wdata, s_axi_wstrb);

   always @(posedge clock) begin
      if (wr_go && w_lpal) begin
         lpal[wa[5:2]] <= m_lp[8:0];
      end
      if (wr_go && w_xpal) begin
         epal[wa[9:2]] <= m_ep[11:0];
      end
   end

   always @(posedge clock) begin
      if (srst) begin
         base         <= `BPV_RST_BASE;
         lmode        <= `BPV_RST_LMODE;
         xmode        <= `BPV_RST_XMODE;
         ctrl         <= `BPV_RST_CTRL;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= 2'h0;
      end else if (ce) begin
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_err ? 2'h2 : 2'h0;
            case (wa)
               // [R14] Top byte not stored
               // [R13] Low three bits dropped
               `BPV_OFF_BASE: begin
                  base <= m_bs[23:3];
               end
               `BPV_OFF_LMODE: begin
                  lmode <= m_lm[1:0];
               end
               // [R18] Hold, grey, mode, bank fields
               `BPV_OFF_XMODE: begin
                  xmode <= m_xm[15:0] & 16'h970F;
               end
               `BPV_OFF_CTRL: begin
                  ctrl <= m_ct[1:0];
               end
               default: begin
                  ctrl <= ctrl;
               end
            endcase
         end
      end
   end

   // ************************************************************
   // Register read channel
   // ************************************************************
   always @* begin
      rd_val = 32'h0;
      rd_err = 1'b0;
      if (ra[11:6] == `BPV_LPAL_TAG) begin
         rd_val = {23'h0, lpal[ra[5:2]]};
      end else if (ra[11:10] == `BPV_XPAL_TAG) begin
         rd_val = {20'h0, epal[ra[9:2]]};
      end else begin
         case (ra)
            `BPV_OFF_BASE:  rd_val = {8'h00, base, 3'h0};
            `BPV_OFF_LMODE: rd_val = {30'h0, lmode};
            `BPV_OFF_XMODE: rd_val = {16'h0, xmode};
            `BPV_OFF_CTRL:  rd_val = {30'h0, ctrl};
            `BPV_OFF_COUNT: rd_val = {8'h00, addr_cnt};
            default:        rd_err = 1'b1;
         endcase
      end
   end

   always @(posedge clock) begin
      if (srst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= 2'h0;
      end else if (ce) begin
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         if (rd_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            s_axi_rresp  <= rd_err ? 2'h2 : 2'h0;
         end
      end
   end
endmodule

// File: bpv_video_properties.sv
`timescale 1ns/1ns
module bpv_video_properties (
   // Clock and control
   input wire        clock,
   input wire        srst,
   input wire        ce,
   // Register bus
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   // Fetch and raster
   input wire        mem_req,
   input wire [23:0] mem_addr,
   input wire        mem_ack,
   input wire        frame_start,
   input wire        pix_tick,
   // Colour
   input wire [7:0]  red,
   input wire [7:0]  green,
   input wire [7:0]  blue
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   // ************************************************************
   // Handshake steps
   // ************************************************************
   sequence s_write_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_read_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_fetch_taken;
      mem_req && mem_ack;
   endsequence
   a_write_answer: assert property (s_write_taken |=> s_axi_bvalid)
      else $error("write not answered next cycle");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
   a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while response pending");
   a_read_answer: assert property (s_read_taken |=> s_axi_rvalid)
      else $error("read not answered next cycle");
   a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
   a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
   a_fetch_step: assert property (s_fetch_taken |=> mem_addr == $past(mem_addr) + 24'h8)
      else $error("fetch address did not step by eight");
   a_fetch_hold: assert property (mem_req && !mem_ack |=> $stable(mem_addr))
      else $error("fetch address moved before ack");
   a_no_fetch_frame: assert property (frame_start |-> !mem_req)
      else $error("fetch during frame reload");
   a_colour_idle: assert property (!(ce && pix_tick) |=> $stable({red, green, blue}))
      else $error("colour changed without pixel tick");
   c_fetch: cover property (s_fetch_taken ##1 s_fetch_taken);
endmodule
bind bpv_video bpv_video_properties u_bpv_video_properties (
   .clock(clock), .srst(srst), .ce(ce), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .mem_req(mem_req),
   .mem_addr(mem_addr), .mem_ack(mem_ack), .frame_start(frame_start), .pix_tick(pix_tick),
   .red(red), .green(green), .blue(blue)
);

// File: bpv_mem_model.sv
`timescale 1ns/1ns
module bpv_mem_model (
   // Clock and reset
   input  wire        clock,
   input  wire        srst,
   // Fetch handshake
   input  wire        mem_req,
   output wire        mem_ack,
   output wire [63:0] mem_data,
   // Test controls
   input  wire        slow,
   input  wire [63:0] pattern
);
   reg [1:0] wait_cnt;
   always @(posedge clock) begin
      if (srst || !mem_req || mem_ack) begin
         wait_cnt <= 2'h0;
      end else begin
         wait_cnt <= wait_cnt + 2'h1;
      end
   end
   assign mem_ack = mem_req && (!slow || wait_cnt == 2'h2);
   // four plane words, lowest address in low bits
   // Inverted outside a transfer so a stale sample shows up
   assign mem_data = mem_ack ? pattern : ~pattern;
endmodule

// File: bpv_video_tb.sv
`timescale 1ns/1ns
`include "bpv_consts.vh"
`define CHK(nm, e, g) begin checks_done = checks_done + 1; if ((g) !== (e)) begin \
   n_mismatch = n_mismatch + 1; $display("unexpected %s exp %h got %h", nm, e, g); end end
module bpv_video_tb;
   reg          clock, srst, frame_start, active, pix_tick, slow;
   reg          awvalid, wvalid, arvalid;
   reg  [11:0]  awaddr, araddr;
   reg  [31:0]  wdata, val;
   reg  [63:0]  pattern;
   reg  [1:0]   resp;
   reg  [23:0]  c0, c1;
   wire         awready, wready, bvalid, arready, rvalid, mem_req, mem_ack;
   wire [1:0]   bresp, rresp;
   wire [31:0]  rdata;
   wire [23:0]  mem_addr;
   wire [63:0]  mem_data;
   wire [7:0]   red, green, blue;
   integer      n_mismatch, checks_done, k;
   bpv_video u_bpv_video (
      .clock(clock), .srst(srst), .ce(1'h1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'h1),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'h1),
      .mem_req(mem_req), .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_data(mem_data),
      .frame_start(frame_start), .active(active), .pix_tick(pix_tick),
      .red(red), .green(green), .blue(blue));
   bpv_mem_model u_bpv_mem_model (.clock(clock), .srst(srst), .mem_req(mem_req),
      .mem_ack(mem_ack), .mem_data(mem_data), .slow(slow), .pattern(pattern));
   initial begin
      clock = 1'h0;
      forever #10 clock = ~clock;
   end
   function [23:0] lc(input [8:0] v);
      lc = {v[8:6], v[8:6], v[8:7], v[5:3], v[5:3], v[5:4], v[2:0], v[2:0], v[2:1]};
   endfunction
   function [23:0] xc(input [11:0] v);
      xc = {v[11:8], v[11:8], v[7:4], v[7:4], v[3:0], v[3:0]};
   endfunction
   // ************************************************************
   // Bus and pixel helpers
   // ************************************************************
   task axi_wr(input [11:0] a, input [31:0] d);
      reg got;
      begin
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'h1;
         wvalid <= 1'h1;
         got = 1'h0;
         while (!got) begin
            @(negedge clock);
            got = awready;
            @(posedge clock);
         end
         awvalid <= 1'h0;
         wvalid <= 1'h0;
         got = 1'h0;
         while (!got) begin
            @(negedge clock);
            got = bvalid;
            resp = bresp;
            @(posedge clock);
         end
      end
   endtask
   task axi_rd(input [11:0] a);
      reg got;
      begin
         araddr <= a;
         arvalid <= 1'h1;
         got = 1'h0;
         while (!got) begin
            @(negedge clock);
            got = arready;
            @(posedge clock);
         end
         arvalid <= 1'h0;
         got = 1'h0;
         while (!got) begin
            @(negedge clock);
            got = rvalid;
            val = rdata;
            resp = rresp;
            @(posedge clock);
         end
      end
   endtask
   // One frame of constant pixels; last colour lands in c0
   task run_pix(input [31:0] ctrl, input [31:0] lm, input [31:0] xm, input [63:0] pat);
      begin
         axi_wr(`BPV_OFF_LMODE, lm);
         axi_wr(`BPV_OFF_XMODE, xm);
         axi_wr(`BPV_OFF_CTRL, ctrl);
         pattern <= pat;
         active <= 1'h1;
         frame_start <= 1'h1;
         @(posedge clock);
         frame_start <= 1'h0;
         repeat (12) @(posedge clock);
         repeat (40) begin
            pix_tick <= 1'h1;
            @(posedge clock);
            pix_tick <= 1'h0;
            @(posedge clock);
         end
         @(negedge clock);
         c0 = {red, green, blue};
         @(posedge clock);
      end
   endtask
   // ************************************************************
   // Scenarios
   // ************************************************************
   task t_regs;
      begin
         axi_rd(`BPV_OFF_CTRL);
         `CHK("ctrl reset", 32'h0, val)
         axi_wr(`BPV_OFF_BASE, 32'hFFFFFFFF);
         axi_rd(`BPV_OFF_BASE);
         `CHK("base", 32'h00FFFFF8, val)
         axi_wr(`BPV_OFF_XMODE, 32'hFFFFFFFF);
         axi_rd(`BPV_OFF_XMODE);
         `CHK("xmode", 32'h0000970F, val)
         axi_wr(`BPV_OFF_COUNT, 32'h0);
         `CHK("count write", 2'h2, resp)
         axi_rd(12'h020);
         `CHK("hole resp", 2'h2, resp)
         `CHK("hole data", 32'h0, val)
      end
   endtask
   task t_fetch;
      begin
         axi_wr(`BPV_OFF_BASE, 32'h00123458);
         axi_wr(`BPV_OFF_CTRL, 32'h1);
         slow <= 1'h1;
         frame_start <= 1'h1;
         @(posedge clock);
         frame_start <= 1'h0;
         @(negedge clock);
         `CHK("reload req", 1'h1, mem_req)
         `CHK("reload addr", 24'h123458, mem_addr)
         while (mem_ack !== 1'h1) @(negedge clock);
         @(negedge clock);
         `CHK("step addr", 24'h123460, mem_addr)
         @(posedge clock);
         slow <= 1'h0;
      end
   endtask
   task t_legacy;
      begin
         axi_wr(12'h100, 32'h0A4);
         axi_wr(12'h104, 32'h1F0);
         axi_wr(12'h114, 32'h13C);
         run_pix(32'h1, 32'h0, 32'h0, 64'h0000FFFF0000FFFF);
         `CHK("mode 00", lc(9'h13C), c0)
         active <= 1'h0;
         pix_tick <= 1'h1;
         @(posedge clock);
         pix_tick <= 1'h0;
         @(negedge clock);
         `CHK("border", lc(9'h0A4), {red, green, blue})
         @(posedge clock);
         run_pix(32'h1, 32'h1, 32'h0, 64'h0000FFFF0000FFFF);
         `CHK("mode 01", lc(9'h1F0), c0)
         run_pix(32'h1, 32'h2, 32'h0, {64{1'h1}});
         c1 = c0;
         `CHK("mono level", 1'h1, (c1 === 24'h0 || c1 === 24'hFFFFFF))
         axi_wr(12'h100, 32'h0A5);
         run_pix(32'h1, 32'h2, 32'h0, {64{1'h1}});
         `CHK("mono invert", ~c1, c0)
         run_pix(32'h1, 32'h3, 32'h0, {64{1'h1}});
         `CHK("legacy reserved", 24'h0, c0)
      end
   endtask
   task t_ext;
      begin
         axi_wr(12'h400, 32'h0);
         axi_wr(12'h544, 32'h3C9);
         axi_wr(12'h664, 32'hA5F);
         axi_wr(12'h7F8, 32'h123);
         axi_wr(12'h7FC, 32'hFED);
         for (k = 0; k < 3; k = k + 1) begin
            run_pix(32'h3, 32'h0, ((k == 2) ? 32'h405 : 32'h5 + 32'h100 * k), 64'hFFFF);
            `CHK("bank", xc(12'h3C9), c0)
         end
         run_pix(32'h3, 32'h0, 32'h0700, 64'hFFFF00000000FFFF);
         `CHK("eight plane", xc(12'hA5F), c0)
         run_pix(32'h3, 32'h0, 32'h1700, 64'hFFFF00000000FFFF);
         `CHK("grey", 24'h5F5F5F, c0)
         run_pix(32'h3, 32'h0, 32'h0200, {64{1'h1}});
         `CHK("duo one", xc(12'hFED), c0)
         axi_wr(12'h100, 32'h0A6);
         run_pix(32'h3, 32'h0, 32'h0200, {64{1'h1}});
         `CHK("duo invert", xc(12'h123), c0)
         run_pix(32'h3, 32'h0, 32'h0300, {64{1'h1}});
         `CHK("ext reserved", 24'h0, c0)
      end
   endtask
   task report_and_stop;
      begin
         $display("checks %0d mismatches %0d", checks_done, n_mismatch);
         if (n_mismatch == 0 && checks_done > 0) begin
            $display("DONE - PASS");
         end else begin
            $display("DONE - FAIL");
         end
         $finish;
      end
   endtask
   initial begin
      n_mismatch = 0;
      checks_done = 0;
      {srst, frame_start, active, pix_tick, slow} = 5'h10;
      {awvalid, wvalid, arvalid, awaddr, araddr, wdata, pattern} = 0;
      repeat (3) @(posedge clock);
      srst <= 1'h0;
      @(posedge clock);
      t_regs;
      t_fetch;
      t_legacy;
      t_ext;
      report_and_stop;
   end
   // Hang guard, about seven times the run
   initial begin
      #200000;
      n_mismatch = n_mismatch + 1;
      report_and_stop;
   end
endmodule
